// File: rtl/peil_event_logic.v
// Contract
// - Rail C high current sets status, interrupt only
// - High temperature sets status, interrupt only
// - Bus packet check error sets status, interrupt only
// - Parity error sets status, interrupt only
// - Outputs hold until host clears; masking releases only the interrupt
// - Unmasked event drives interrupt low, power-good per class
// - Clear after event releases interrupt, faults keep power-good
// - Unmasked clear identical for modes 00, 01, 10
// - Masked mode 00 event keeps interrupt high
// - Masked mode 00 clear keeps interrupt high
// - Current warnings never drop power-good
// - Disable triggers issue internal regulator disable
// - Interrupt alone never changes regulator operation
`timescale 1ns/1ps
`include "peil_regs.vh"

module peil_event_logic #(
	parameter NUM_EV = `PEIL_NUM_EV
) (
	// Clock and reset
	input  wire              mclk,
	input  wire              resetn,
	// Raw event conditions from analog detectors
	input  wire [NUM_EV-1:0] event_raw,
	input  wire              crit_temp_raw,
	// Host controls
	input  wire [NUM_EV-1:0] clear_pulse,
	input  wire [NUM_EV-1:0] mask_bits,
	input  wire [1:0]        mask_response_mode,
	input  wire [2:0]        hot_threshold,
	// Status and outputs
	output reg  [NUM_EV-1:0] status_q,
	output reg               crit_temp_status_q,
	output reg               general_status_irq_n,
	output reg               power_ok_out,
	output reg               vr_disable_q,
	output reg  [2:0]        hot_threshold_q
);

	// Event class maps
	localparam [NUM_EV-1:0] PG_CLASS    = `PEIL_PG_CLASS;
	localparam [NUM_EV-1:0] FAULT_CLASS = `PEIL_FAULT_CLASS;
	localparam [NUM_EV-1:0] DIS_CLASS   = `PEIL_DIS_CLASS;
	localparam [NUM_EV-1:0] STATUS_RST  = `PEIL_STATUS_RST;

	// Per-event tracking states
	localparam [1:0]        EV_IDLE     = 2'h0;
	localparam [1:0]        EV_ACTIVE   = 2'h1;
	localparam [1:0]        EV_HELD     = 2'h2;

	// Synchroniser stages
	reg  [NUM_EV-1:0] ev_s1_q;
	reg  [NUM_EV-1:0] ev_s2_q;
	reg               crit_s1_q;
	reg               crit_s2_q;

	// Per-event next status and output contributions
	wire [NUM_EV-1:0] status_d;
	wire [NUM_EV-1:0] irq_vec;
	wire [NUM_EV-1:0] pg_vec;
	wire [NUM_EV-1:0] dis_vec;

	// Summaries feeding the output flops
	wire              crit_d;
	wire              irq_any;
	wire              pg_low_any;
	wire              dis_any;
	reg               masked_pg_counts;
	reg               irq_n_d;
	reg               power_ok_d;
	reg               vr_disable_d;

	// Two-flop synchronisers for the detector levels
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ev_s1_q <= STATUS_RST;
			ev_s2_q <= STATUS_RST;
		end else begin
			ev_s1_q <= event_raw;
			ev_s2_q <= ev_s1_q;
		end
	end

	// Critical temperature detector synchroniser
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			crit_s1_q <= 1'b0;
			crit_s2_q <= 1'b0;
		end else begin
			crit_s1_q <= crit_temp_raw;
			crit_s2_q <= crit_s1_q;
		end
	end

	// Masked power-good response; codes 00, 01, 10 and default all count masked events
	always @* begin
		case (mask_response_mode)
			`PEIL_MODE_00: begin
				masked_pg_counts = 1'b1;
			end
			`PEIL_MODE_01: begin
				masked_pg_counts = 1'b1;
			end
			`PEIL_MODE_10: begin
				masked_pg_counts = 1'b1;
			end
			default: begin
				masked_pg_counts = 1'b1;
			end
		endcase
	end

	// Per-event tracking: idle, present, or gone awaiting a clear
	genvar i;
	generate
		for (i = 0; i < NUM_EV; i = i + 1) begin : g_ev
			// Per-event state
			reg  [1:0] state_q;
			reg  [1:0] state_d;
			reg        fault_q;
			wire       fault_d;
			wire       present;
			wire       clr_req;

			// Per-event output bits
			reg        irq_bit;
			reg        pg_bit;
			reg        dis_bit;

			// Synchronised level and clear strobe
			assign present = ev_s2_q[i];
			assign clr_req = clear_pulse[i];

			// A present event refuses the clear; set wins
			always @* begin
				state_d = state_q;
				case (state_q)
					// Nothing pending
					EV_IDLE: begin
						if (present) begin
							state_d = EV_ACTIVE;
						end
					end
					// Event still present
					EV_ACTIVE: begin
						if (!present && clr_req) begin
							state_d = EV_IDLE;
						end else if (!present) begin
							state_d = EV_HELD;
						end
					end
					// Event gone, status held
					EV_HELD: begin
						if (present) begin
							state_d = EV_ACTIVE;
						end else if (clr_req) begin
							state_d = EV_IDLE;
						end
					end
					default: begin
						state_d = EV_IDLE;
					end
				endcase
			end

			// Per-event state register
			always @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					state_q <= EV_IDLE;
				end else begin
					state_q <= state_d;
				end
			end

			// Faults hold power-good low past a clear until reset
			assign fault_d = fault_q |
				(present & FAULT_CLASS[i]);

			// Per-event fault latch
			always @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					fault_q <= 1'b0;
				end else begin
					fault_q <= fault_d;
				end
			end

			// Status stands while the event is not idle
			assign status_d[i] = (state_d != EV_IDLE);

			// Per-event contributions to the three outputs
			always @* begin
				irq_bit = 1'b0;
				pg_bit  = 1'b0;
				dis_bit = 1'b0;
				if (status_d[i]) begin
					// Masked events stay off the interrupt
					if (!mask_bits[i]) begin
						irq_bit = 1'b1;
					end
					// Power-good events count even when masked
					if (PG_CLASS[i] && (!mask_bits[i] || masked_pg_counts)) begin
						pg_bit = 1'b1;
					end
					if (DIS_CLASS[i]) begin
						dis_bit = 1'b1;
					end
				end
				if (fault_d) begin
					pg_bit = 1'b1;
				end
			end

			// Collect per-event bits
			assign irq_vec[i] = irq_bit;
			assign pg_vec[i]  = pg_bit;
			assign dis_vec[i] = dis_bit;
		end
	endgenerate

	// Critical temperature is sticky until reset and has no mask
	assign crit_d = crit_temp_status_q | crit_s2_q;

	// Any-event summaries
	assign irq_any    = |irq_vec;
	assign pg_low_any = |pg_vec;
	assign dis_any    = |dis_vec;

	// Next output levels
	always @* begin
		irq_n_d      = 1'b1;
		power_ok_d   = 1'b1;
		vr_disable_d = 1'b0;
		if (irq_any || crit_d) begin
			irq_n_d = 1'b0;
		end
		// Current warnings never sit in the power-good sum
		if (pg_low_any || crit_d) begin
			power_ok_d = 1'b0;
		end
		// The interrupt alone never disables a regulator
		if (dis_any || crit_d) begin
			vr_disable_d = 1'b1;
		end
	end

	// Sticky status register
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			status_q <= STATUS_RST;
		end else begin
			status_q <= status_d;
		end
	end

	// Sticky critical temperature status
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			crit_temp_status_q <= 1'b0;
		end else begin
			crit_temp_status_q <= crit_d;
		end
	end

	// Interrupt output, active low
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			general_status_irq_n <= 1'b1;
		end else begin
			general_status_irq_n <= irq_n_d;
		end
	end

	// Power-good output
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			power_ok_out <= 1'b0;
		end else begin
			power_ok_out <= power_ok_d;
		end
	end

	// Internal regulator disable
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			vr_disable_q <= 1'b0;
		end else begin
			vr_disable_q <= vr_disable_d;
		end
	end

	// Threshold for the high temperature warning
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			hot_threshold_q <= 3'h0;
		end else begin
			hot_threshold_q <= hot_threshold;
		end
	end

endmodule

// File: rtl/peil_regs.vh
`ifndef PEIL_REGS_VH
`define PEIL_REGS_VH

// Event indices
`define PEIL_EV_VIN_OV     0
`define PEIL_EV_PG_A       1
`define PEIL_EV_PG_B       2
`define PEIL_EV_PG_C       3
`define PEIL_EV_PG_L18     4
`define PEIL_EV_PG_L10     5
`define PEIL_EV_OV_A       6
`define PEIL_EV_OV_B       7
`define PEIL_EV_OV_C       8
`define PEIL_EV_UV_A       9
`define PEIL_EV_UV_B       10
`define PEIL_EV_UV_C       11
`define PEIL_EV_CL_A       12
`define PEIL_EV_CL_B       13
`define PEIL_EV_CL_C       14
`define PEIL_EV_HC_A       15
`define PEIL_EV_HC_B       16
`define PEIL_EV_HC_C       17
`define PEIL_EV_HOT        18
`define PEIL_EV_PEC        19
`define PEIL_EV_PAR        20
`define PEIL_NUM_EV        21

// Events that pull power-good low while pending (power-good class)
`define PEIL_PG_CLASS      21'h00003e
// Events that latch power-good low until reset (faults)
`define PEIL_FAULT_CLASS   21'h000fc1
// Events that issue an internal regulator disable
`define PEIL_DIS_CLASS     21'h000fc1

// Mask response mode codes
`define PEIL_MODE_00       2'h0
`define PEIL_MODE_01       2'h1
`define PEIL_MODE_10       2'h2

// Reset values
`define PEIL_STATUS_RST    21'h000000

`endif

// File: verification/peil_chk_sva.sv
`timescale 1ns/1ps
module peil_chk (
	input wire        mclk, resetn, crit_temp_status_q, power_ok_out,
	input wire        general_status_irq_n, vr_disable_q,
	input wire [20:0] event_raw, clear_pulse, mask_bits, status_q,
	input wire [2:0]  hot_threshold, hot_threshold_q
);
	wire irq = !general_status_irq_n, c = crit_temp_status_q;
	wire [20:0] s = status_q, m = status_q & ~mask_bits;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	sequence s_gone; !event_raw[17] [*4] ##0 clear_pulse[17]; endsequence
	property p_clr; s_gone |=> !s[17]; endproperty
	a_clr: assert property (p_clr) else $error("kept");
	property p_set; event_raw[19] |-> ##3 s[19]; endproperty
	a_set: assert property (p_set) else $error("late");
	property p_lo; |m && $stable(mask_bits) |-> irq; endproperty
	a_lo: assert property (p_lo) else $error("high");
	property p_hi; !m && !c && $stable(mask_bits) |-> !irq; endproperty
	a_hi: assert property (p_hi) else $error("low");
	property p_hold; !($past(s) & ~s & ~$past(clear_pulse)); endproperty
	a_hold: assert property (p_hold) else $error("lost");
	property p_pok; $fell(power_ok_out) |-> |(s & 21'hfff) || c; endproperty
	a_pok: assert property (p_pok) else $error("drop");
	property p_dis; vr_disable_q |-> |(s & 21'hfc1) || c; endproperty
	a_dis: assert property (p_dis) else $error("off");
	property p_crit; c |-> irq && !power_ok_out && vr_disable_q; endproperty
	a_crit: assert property (p_crit) else $error("crit");
	property p_thr;
		$past(resetn) |-> hot_threshold_q == $past(hot_threshold);
	endproperty
	a_thr: assert property (p_thr) else $error("thr");
	property p_dis_on; |(s & 21'hfc1) || c |-> vr_disable_q; endproperty
	a_dis_on: assert property (p_dis_on) else $error("on");
endmodule

// File: verification/peil_host_model.sv
`timescale 1ns/1ps
module peil_host_model (
	input wire        mclk, host_en, general_status_irq_n, power_ok_out,
	input wire [20:0] status_q,
	output reg [20:0] clear_pulse = 21'h0
);
	always @(posedge mclk)
		clear_pulse <= host_en && !clear_pulse &&
			!(general_status_irq_n && power_ok_out) ? status_q : 21'h0;
endmodule

// File: verification/peil_event_logic_tb.sv
`timescale 1ns/1ps
module peil_event_logic_tb;
	reg mclk = 0, resetn = 0, crit_temp_raw = 0, host_en = 0;
	reg [20:0] event_raw = 0, mask_bits = 0;
	reg [1:0] mask_response_mode = 0;
	reg [2:0] hot_threshold = 0;
	wire [2:0] hot_threshold_q;
	wire [20:0] clear_pulse, status_q;
	wire general_status_irq_n, power_ok_out, vr_disable_q, crit_temp_status_q;
	wire [1:0] o = {general_status_irq_n, power_ok_out};
	int miscompares, n_tests;
	logic [1:0] q[$];
	event tick;
	peil_event_logic peil_event_logic_inst (
		.mclk(mclk), .resetn(resetn), .event_raw(event_raw),
		.crit_temp_raw(crit_temp_raw), .clear_pulse(clear_pulse),
		.mask_bits(mask_bits), .mask_response_mode(mask_response_mode),
		.hot_threshold(hot_threshold), .status_q(status_q),
		.crit_temp_status_q(crit_temp_status_q),
		.general_status_irq_n(general_status_irq_n),
		.power_ok_out(power_ok_out), .vr_disable_q(vr_disable_q),
		.hot_threshold_q(hot_threshold_q));
	peil_host_model peil_host_model_inst (.mclk(mclk), .host_en(host_en),
		.general_status_irq_n(general_status_irq_n),
		.power_ok_out(power_ok_out), .status_q(status_q),
		.clear_pulse(clear_pulse));
	initial forever #12.5 mclk = ~mclk;
	task automatic note(int n, logic [1:0] e);
		repeat (n) @(posedge mclk);
		#1 q.push_back(e);
		->tick;
	endtask
	always @(tick) begin
		n_tests++;
		if (o !== q[0]) begin
			miscompares++;
			$display("MISMATCH out exp %b got %b", q[0], o);
		end
		void'(q.pop_front());
	end
	task automatic run(int i, logic [1:0] m, a, b);
		mask_response_mode <= m;
		hot_threshold <= $urandom % 8;
		event_raw[i] <= 1;
		note(5, a);
		event_raw[i] <= 0;
		note(6, a);
		host_en <= 1;
		note(4, b);
		host_en <= 0;
	endtask
	task automatic report_and_stop;
		$display("tests %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#20us miscompares++;
		report_and_stop;
	end
	initial begin
		void'($urandom(32'h3aec));
		note(8, 2'b10);
		resetn <= 1;
		note(1, 2'b11);
		for (int k = 0; k < 6; k++)
			run(k < 5 ? 16 + k : 12 + $urandom % 9, k % 3, 2'b01,
				2'b11);
		mask_bits <= '1;
		run(1, 0, 2'b10, 2'b11);
		mask_bits <= 0;
		run(6, 1, 2'b00, 2'b10);
		crit_temp_raw <= 1;
		note(5, 2'b00);
		report_and_stop;
	end
endmodule
bind peil_event_logic peil_chk peil_chk_inst (.mclk(mclk), .resetn(resetn),
	.crit_temp_status_q(crit_temp_status_q), .power_ok_out(power_ok_out),
	.general_status_irq_n(general_status_irq_n),
	.vr_disable_q(vr_disable_q), .event_raw(event_raw),
	.clear_pulse(clear_pulse), .mask_bits(mask_bits), .status_q(status_q),
	.hot_threshold(hot_threshold), .hot_threshold_q(hot_threshold_q));
